// [pkg/rsr_pkg.sv]
// Function
// - Answer bus address 40h or 41h
// - Start and stop positions, twelve bits each
// - Power mode field bits 1:0
// - Hysteresis field bits 3:2
// - Output stage field bits 5:4
// - Pulse rate field bits 7:6
// - Slow filter field bits 9:8
// - Fast threshold field bits 12:10
// - Config loads programmed value at power-up
// - Command 80h burns positions, 40h config
// - Status flags in bits 0 to 6
// - Overflow sticky, cleared by writing 00h
// - Pointer holds on reads of output high bytes
// - Position burn twice, magnet needed
package rsr_pkg;
   localparam logic [6:0] ADDR_LOWER_DIE = 7'h40;
   localparam logic [6:0] ADDR_UPPER_DIE = 7'h41;
   localparam logic [7:0] OFS_START_HI = 8'h01;
   localparam logic [7:0] OFS_START_LO = 8'h02;
   localparam logic [7:0] OFS_STOP_HI = 8'h03;
   localparam logic [7:0] OFS_STOP_LO = 8'h04;
   localparam logic [7:0] OFS_CONFIG_HI = 8'h07;
   localparam logic [7:0] OFS_CONFIG_LO = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0B;
   localparam logic [7:0] OFS_RAW_HI = 8'h0C;
   localparam logic [7:0] OFS_RAW_LO = 8'h0D;
   localparam logic [7:0] OFS_ANGLE_HI = 8'h0E;
   localparam logic [7:0] OFS_ANGLE_LO = 8'h0F;
   localparam logic [7:0] OFS_GAIN = 8'h1A;
   localparam logic [7:0] OFS_MAG_HI = 8'h1B;
   localparam logic [7:0] OFS_MAG_LO = 8'h1C;
   localparam logic [7:0] OFS_BURN = 8'hFF;
   localparam logic [7:0] CMD_BURN_POSITION = 8'h80;
   localparam logic [7:0] CMD_BURN_CONFIG = 8'h40;
   localparam logic [7:0] STATUS_CLEAR_VALUE = 8'h00;
   localparam logic [1:0] POSITION_BURN_LIMIT = 2'h2;
   localparam int CONFIG_WIDTH = 14;
   localparam int POWER_LSB = 0;
   localparam int HYSTERESIS_SEL_LSB = 2;
   localparam int OUTSTAGE_LSB = 4;
   localparam int RATE_LSB = 6;
   localparam int SLOW_LSB = 8;
   localparam int FAST_LSB = 10;
   localparam int AUTO_LP_BIT = 13;
   localparam int STAT_OFS0 = 0;
   localparam int STAT_OFS1 = 1;
   localparam int STAT_GAIN = 2;
   localparam int STAT_STRONG = 3;
   localparam int STAT_WEAK = 4;
   localparam int STAT_MAGNET = 5;
   localparam int STAT_OVERFLOW = 6;
   localparam int RAW_BUSY_BIT = 14;
   localparam int RAW_FAST_BIT = 15;
   localparam logic [11:0] POSITION_RESET = 12'h000;
   localparam logic [13:0] CONFIG_RESET = 14'h0000;

   typedef enum logic [1:0] {
      RSR_NORMAL_POWER, RSR_LOW_POWER_ONE, RSR_LOW_POWER_TWO, RSR_LOW_POWER_THREE
   } rsr_power_type;

   typedef struct packed {
      logic [15:0] raw_angle;
      logic [11:0] angle;
      logic [7:0] gain;
      logic [11:0] magnitude;
      logic [5:0] status_flags;
      logic overflow_event;
   } rsr_sense_type;

   typedef struct packed {
      rsr_power_type power_mode_sel;
      logic [1:0] hysteresis_sel;
      logic [1:0] output_stage_sel;
      logic pwm_enable;
      logic [1:0] pulse_rate_sel;
      logic [1:0] slow_filter_sel;
      logic [2:0] fast_threshold_sel;
      logic auto_low_power_timer;
   } rsr_ctrl_type;
endpackage : rsr_pkg

// [sim/rsr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rsr_host_model (
   input wire logic clk,
   output logic ptr_load,
   output logic [7:0] ptr_value,
   output logic wr_strobe,
   output logic [7:0] wr_data,
   output logic rd_strobe,
   output logic sample
);
   initial begin
      {ptr_load, wr_strobe, rd_strobe, sample} = 4'h0;
      {ptr_value, wr_data} = 16'h5AA5;
   end
   task automatic point(input logic [7:0] a);
      @(negedge clk);
      ptr_load = 1'b1;
      ptr_value = a;
      @(negedge clk);
      ptr_load = 1'b0;
      ptr_value = ~a;
      @(negedge clk);
   endtask : point
   // One byte: write when wr, otherwise read
   task automatic beat(input logic wr, input logic [7:0] d);
      @(negedge clk);
      {wr_strobe, rd_strobe, sample, wr_data} = {wr, !wr, !wr, d};
      @(negedge clk);
      {wr_strobe, rd_strobe, sample, wr_data} = {3'h0, ~d};
   endtask : beat
endmodule : rsr_host_model
`default_nettype wire

// [sim/rsr_register_bank_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module rsr_register_bank_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic die_select,
   input wire logic [6:0] bus_addr,
   input wire logic bus_addr_valid,
   input wire logic ptr_load,
   input wire logic wr_strobe,
   input wire logic [7:0] wr_data,
   input wire logic rd_strobe,
   input wire logic addr_match,
   input wire logic [7:0] rd_data,
   input wire logic ack_valid,
   input wire logic [7:0] pointer,
   input wire rsr_pkg::rsr_ctrl_type ctrl,
   input wire logic burn_position,
   input wire logic burn_config,
   input wire logic [1:0] burn_count
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_match_own: assert property (bus_addr_valid && bus_addr == {6'h20, die_select} |=> addr_match)
      else $error("own bus address not matched");
   a_match_other: assert property (bus_addr_valid && bus_addr != {6'h20, die_select} |=> !addr_match)
      else $error("foreign bus address matched");
   a_pwm_stage: assert property (ctrl.pwm_enable == (ctrl.output_stage_sel == 2'b10))
      else $error("pwm enable disagrees with output stage");
   // Pointer port shows the internal pointer one cycle late
   a_ptr_hold: assert property (rd_strobe && !ptr_load ##1 pointer inside {8'h0C, 8'h0E, 8'h1B}
      |=> $stable(pointer)) else $error("pointer moved on output high byte");
   a_ptr_step: assert property (rd_strobe && !ptr_load ##1 !(pointer inside {8'h0C, 8'h0E, 8'h1B})
      |=> pointer == $past(pointer) + 8'h01) else $error("pointer not stepped after read");
   a_wr_step: assert property (wr_strobe && !ptr_load |=> ##1 pointer == $past(pointer) + 8'h01)
      else $error("pointer not stepped after write");
   a_burn_cfg: assert property (wr_strobe && !ptr_load && wr_data == 8'h40 ##1 pointer == 8'hFF
      |-> burn_config ##1 !burn_config) else $error("config burn pulse wrong");
   a_burn_limit: assert property ($past(burn_count) == 2'h2 |-> !burn_position)
      else $error("position burn beyond limit");
   a_unmapped_zero: assert property (!ack_valid |-> rd_data == 8'h00)
      else $error("unmapped read not zero");
endmodule : rsr_register_bank_assertions
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic die_select;
   logic bus_addr_valid;
   logic [6:0] bus_addr;
   logic ptr_load, wr_strobe, rd_strobe, sample, addr_match, ack_valid, burn_position, burn_config;
   logic [7:0] ptr_value, wr_data, rd_data, pointer, raw_hi;
   logic [11:0] otp_start, otp_stop, start_position, stop_position, start, stop;
   logic [13:0] otp_config, cfg;
   logic [1:0] burn_count;
   logic [7:0] exp_q[$];
   rsr_pkg::rsr_sense_type sense;
   rsr_pkg::rsr_ctrl_type ctrl, exp_ctrl;
   int miscompares = 0;
   int total_checks = 0;
   int pos_pulses = 0;
   int cfg_pulses = 0;
   int seed = 32'h2BE9;
   rsr_host_model host (.*);
   rsr_register_bank DUT (.*);
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : compare
   task automatic expect_rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
      exp_q.push_back(e0);
      exp_q.push_back(e1);
      host.point(a);
      host.beat(1'b0, 8'h00);
      host.beat(1'b0, 8'h00);
   endtask : expect_rd
   task automatic wrap_up();
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      pos_pulses <= pos_pulses + int'(burn_position === 1'b1);
      cfg_pulses <= cfg_pulses + int'(burn_config === 1'b1);
      if (sample === 1'b1) begin
         compare(rd_data, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      wrap_up();
   end
   initial begin
      {die_select, bus_addr_valid, bus_addr} = 9'h000;
      sense = '0;
      otp_start = 12'($random(seed));
      otp_stop = 12'($random(seed));
      otp_config = 14'($random(seed));
      cfg = otp_config;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      expect_rd(8'h01, {4'h0, otp_start[11:8]}, otp_start[7:0]);
      expect_rd(8'h03, {4'h0, otp_stop[11:8]}, otp_stop[7:0]);
      for (int i = 0; i < 8; i++) begin
         die_select = i[0];
         bus_addr = (i < 4) ? 7'h40 + 7'(i[1]) : 7'($random(seed));
         bus_addr_valid = 1'b1;
         @(negedge clk);
         compare(addr_match, bus_addr == {6'h20, die_select});
      end
      bus_addr_valid = 1'b0;
      for (int i = 0; i < 8; i++) begin
         expect_rd(8'h07, {2'h0, cfg[13:8]}, cfg[7:0]);
         cfg = {i[0], i[2:0], {5{i[1:0]}}};
         host.point(8'h07);
         host.beat(1'b1, {2'h3, cfg[13:8]});
         host.beat(1'b1, cfg[7:0]);
         @(negedge clk);
         exp_ctrl = '{rsr_pkg::rsr_power_type'(cfg[1:0]), cfg[3:2], cfg[5:4], cfg[5:4] == 2'h2,
            cfg[7:6], cfg[9:8], cfg[12:10], cfg[13]};
         compare(32'(ctrl), 32'(exp_ctrl));
      end
      start = 12'($random(seed));
      stop = start + 12'd300;
      host.point(8'h01);
      // Upper nibble of high bytes set to show it is dropped
      for (int k = 0; k < 4; k++) begin
         host.beat(1'b1, (k % 2 == 0) ? {4'hF, ((k < 2) ? start[11:8] : stop[11:8])} :
            ((k < 2) ? start[7:0] : stop[7:0]));
      end
      expect_rd(8'h01, {4'h0, start[11:8]}, start[7:0]);
      expect_rd(8'h03, {4'h0, stop[11:8]}, stop[7:0]);
      compare({start_position, stop_position}, {start, stop});
      sense = 55'({$random(seed), $random(seed)});
      sense.raw_angle[13:12] = 2'h0;
      sense.overflow_event = 1'b0;
      sense.status_flags = 6'h2A;
      raw_hi = {sense.raw_angle[15:14], 2'h0, sense.raw_angle[11:8]};
      host.point(8'h0E);
      host.beat(1'b1, 8'hFF);
      host.beat(1'b1, 8'hFF);
      expect_rd(8'h0C, raw_hi, raw_hi);
      expect_rd(8'h0D, sense.raw_angle[7:0], {4'h0, sense.angle[11:8]});
      expect_rd(8'h0E, {4'h0, sense.angle[11:8]}, {4'h0, sense.angle[11:8]});
      compare({ack_valid, pointer}, {1'b1, 8'h0E});
      expect_rd(8'h0F, sense.angle[7:0], 8'h00);
      compare({ack_valid, pointer}, {1'b0, 8'h10});
      expect_rd(8'h1A, sense.gain, {4'h0, sense.magnitude[11:8]});
      expect_rd(8'h1B, {4'h0, sense.magnitude[11:8]}, {4'h0, sense.magnitude[11:8]});
      expect_rd(8'hFF, 8'h00, 8'h00);
      sense.overflow_event = 1'b1;
      @(negedge clk);
      sense.overflow_event = 1'b0;
      expect_rd(8'h0B, 8'h6A, raw_hi);
      host.point(8'h0B);
      host.beat(1'b1, 8'h55);
      expect_rd(8'h0B, 8'h6A, raw_hi);
      host.point(8'h0B);
      host.beat(1'b1, 8'h00);
      expect_rd(8'h0B, 8'h2A, raw_hi);
      for (int i = 0; i < 5; i++) begin
         sense.status_flags = (i == 0) ? 6'h0A : 6'h2A;
         host.point(8'hFF);
         host.beat(1'b1, (i == 4) ? 8'h40 : 8'h80);
      end
      repeat (3) @(negedge clk);
      compare(pos_pulses, 2);
      compare(cfg_pulses, 1);
      compare(burn_count, 2'h2);
      rst = 1'b1;
      otp_start = ~otp_start;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      compare(start_position, otp_start);
      compare(exp_q.size(), 0);
      wrap_up();
   end
endmodule : tb_top
bind rsr_register_bank rsr_register_bank_assertions chk (.*);
`default_nettype wire

// [src/rsr_pointer.sv]
`timescale 1ns/1ps
`default_nettype none
module rsr_pointer (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [7:0] load_value,
   input wire logic step,
   input wire logic is_read,
   output logic [7:0] pointer
);
   logic [7:0] next_pointer;
   logic hold;

   always_comb begin
      hold = is_read && (pointer == rsr_pkg::OFS_RAW_HI || pointer == rsr_pkg::OFS_ANGLE_HI ||
         pointer == rsr_pkg::OFS_MAG_HI);
      next_pointer = pointer;
      if (load) begin
         next_pointer = load_value;
      end else if (step && !hold) begin
         next_pointer = pointer + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pointer <= 8'h00;
      end else begin
         pointer <= next_pointer;
      end
   end
endmodule : rsr_pointer
`default_nettype wire

// [src/rsr_register_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module rsr_register_bank (
   input wire logic clk,
   input wire logic rst,
   input wire logic die_select,
   input wire logic [6:0] bus_addr,
   input wire logic bus_addr_valid,
   input wire logic ptr_load,
   input wire logic [7:0] ptr_value,
   input wire logic wr_strobe,
   input wire logic [7:0] wr_data,
   input wire logic rd_strobe,
   input wire logic [11:0] otp_start,
   input wire logic [11:0] otp_stop,
   input wire logic [13:0] otp_config,
   input wire rsr_pkg::rsr_sense_type sense,
   output logic addr_match,
   output logic [7:0] rd_data,
   output logic ack_valid,
   output logic [7:0] pointer,
   output rsr_pkg::rsr_ctrl_type ctrl,
   output logic [11:0] start_position,
   output logic [11:0] stop_position,
   output logic burn_position,
   output logic burn_config,
   output logic [1:0] burn_count
);
   logic [11:0] next_start_position;
   logic [11:0] next_stop_position;
   logic [13:0] config_value;
   logic [13:0] next_config_value;
   logic overflow_flag;
   logic next_overflow_flag;
   logic next_burn_position;
   logic next_burn_config;
   logic [1:0] next_burn_count;
   logic next_addr_match;
   logic [7:0] next_rd_data;
   logic next_ack_valid;
   logic [7:0] status_value;
   rsr_pkg::rsr_ctrl_type next_ctrl;
   logic loaded;
   logic next_loaded;
   logic [7:0] rd_ptr;
   logic valid_addr;

   rsr_pointer u_pointer (
      .clk(clk),
      .rst(rst),
      .load(ptr_load),
      .load_value(ptr_value),
      .step(wr_strobe || rd_strobe),
      .is_read(rd_strobe),
      .pointer(rd_ptr)
   );

   always_comb begin
      status_value = {1'b0, overflow_flag, sense.status_flags};
   end

   always_comb begin
      valid_addr = 1'b0;
      unique case (rd_ptr)
         rsr_pkg::OFS_START_HI, rsr_pkg::OFS_START_LO, rsr_pkg::OFS_STOP_HI,
         rsr_pkg::OFS_STOP_LO, rsr_pkg::OFS_CONFIG_HI, rsr_pkg::OFS_CONFIG_LO,
         rsr_pkg::OFS_STATUS, rsr_pkg::OFS_RAW_HI, rsr_pkg::OFS_RAW_LO,
         rsr_pkg::OFS_ANGLE_HI, rsr_pkg::OFS_ANGLE_LO, rsr_pkg::OFS_GAIN,
         rsr_pkg::OFS_MAG_HI, rsr_pkg::OFS_MAG_LO, rsr_pkg::OFS_BURN: begin
            valid_addr = 1'b1;
         end
         default: begin
            valid_addr = 1'b0;
         end
      endcase
   end

   always_comb begin
      next_addr_match = bus_addr_valid &&
         (bus_addr == (die_select ? rsr_pkg::ADDR_UPPER_DIE : rsr_pkg::ADDR_LOWER_DIE));
      next_ack_valid = valid_addr;
      next_rd_data = 8'h00;
      unique case (rd_ptr)
         rsr_pkg::OFS_START_HI: begin
            next_rd_data = {4'h0, start_position[11:8]};
         end
         rsr_pkg::OFS_START_LO: begin
            next_rd_data = start_position[7:0];
         end
         rsr_pkg::OFS_STOP_HI: begin
            next_rd_data = {4'h0, stop_position[11:8]};
         end
         rsr_pkg::OFS_STOP_LO: begin
            next_rd_data = stop_position[7:0];
         end
         rsr_pkg::OFS_CONFIG_HI: begin
            next_rd_data = {2'h0, config_value[13:8]};
         end
         rsr_pkg::OFS_CONFIG_LO: begin
            next_rd_data = config_value[7:0];
         end
         rsr_pkg::OFS_STATUS: begin
            next_rd_data = status_value;
         end
         rsr_pkg::OFS_RAW_HI: begin
            next_rd_data = {sense.raw_angle[rsr_pkg::RAW_FAST_BIT],
               sense.raw_angle[rsr_pkg::RAW_BUSY_BIT], 2'h0, sense.raw_angle[11:8]};
         end
         rsr_pkg::OFS_RAW_LO: begin
            next_rd_data = sense.raw_angle[7:0];
         end
         rsr_pkg::OFS_ANGLE_HI: begin
            next_rd_data = {4'h0, sense.angle[11:8]};
         end
         rsr_pkg::OFS_ANGLE_LO: begin
            next_rd_data = sense.angle[7:0];
         end
         rsr_pkg::OFS_GAIN: begin
            next_rd_data = sense.gain;
         end
         rsr_pkg::OFS_MAG_HI: begin
            next_rd_data = {4'h0, sense.magnitude[11:8]};
         end
         rsr_pkg::OFS_MAG_LO: begin
            next_rd_data = sense.magnitude[7:0];
         end
         default: begin
            next_rd_data = 8'h00;
         end
      endcase
   end

   always_comb begin
      next_loaded = 1'b1;
      next_start_position = start_position;
      next_stop_position = stop_position;
      next_config_value = config_value;
      next_overflow_flag = overflow_flag;
      next_burn_position = 1'b0;
      next_burn_config = 1'b0;
      next_burn_count = burn_count;
      if (!loaded) begin
         next_start_position = otp_start;
         next_stop_position = otp_stop;
         next_config_value = otp_config;
      end else if (wr_strobe) begin
         unique case (rd_ptr)
            rsr_pkg::OFS_START_HI: begin
               next_start_position[11:8] = wr_data[3:0];
            end
            rsr_pkg::OFS_START_LO: begin
               next_start_position[7:0] = wr_data;
            end
            rsr_pkg::OFS_STOP_HI: begin
               next_stop_position[11:8] = wr_data[3:0];
            end
            rsr_pkg::OFS_STOP_LO: begin
               next_stop_position[7:0] = wr_data;
            end
            rsr_pkg::OFS_CONFIG_HI: begin
               next_config_value[13:8] = wr_data[5:0];
            end
            rsr_pkg::OFS_CONFIG_LO: begin
               next_config_value[7:0] = wr_data;
            end
            rsr_pkg::OFS_STATUS: begin
               if (wr_data == rsr_pkg::STATUS_CLEAR_VALUE) begin
                  next_overflow_flag = 1'b0;
               end
            end
            rsr_pkg::OFS_BURN: begin
               if (wr_data == rsr_pkg::CMD_BURN_POSITION &&
                  sense.status_flags[rsr_pkg::STAT_MAGNET] &&
                  burn_count < rsr_pkg::POSITION_BURN_LIMIT) begin
                  next_burn_position = 1'b1;
                  next_burn_count = burn_count + 2'h1;
               end
               if (wr_data == rsr_pkg::CMD_BURN_CONFIG) begin
                  next_burn_config = 1'b1;
               end
            end
            default: begin
               next_start_position = start_position;
            end
         endcase
      end
      if (sense.overflow_event) begin
         next_overflow_flag = 1'b1;
      end
   end

   always_comb begin
      next_ctrl.power_mode_sel =
         rsr_pkg::rsr_power_type'(config_value[rsr_pkg::POWER_LSB +: 2]);
      next_ctrl.hysteresis_sel = config_value[rsr_pkg::HYSTERESIS_SEL_LSB +: 2];
      next_ctrl.output_stage_sel = config_value[rsr_pkg::OUTSTAGE_LSB +: 2];
      next_ctrl.pwm_enable = config_value[rsr_pkg::OUTSTAGE_LSB +: 2] == 2'h2;
      next_ctrl.pulse_rate_sel = config_value[rsr_pkg::RATE_LSB +: 2];
      next_ctrl.slow_filter_sel = config_value[rsr_pkg::SLOW_LSB +: 2];
      next_ctrl.fast_threshold_sel = config_value[rsr_pkg::FAST_LSB +: 3];
      next_ctrl.auto_low_power_timer = config_value[rsr_pkg::AUTO_LP_BIT];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         loaded <= 1'b0;
         start_position <= rsr_pkg::POSITION_RESET;
         stop_position <= rsr_pkg::POSITION_RESET;
         config_value <= rsr_pkg::CONFIG_RESET;
         overflow_flag <= 1'b0;
         burn_position <= 1'b0;
         burn_config <= 1'b0;
         burn_count <= 2'h0;
         addr_match <= 1'b0;
         rd_data <= 8'h00;
         ack_valid <= 1'b0;
         pointer <= 8'h00;
         ctrl <= '0;
      end else begin
         loaded <= next_loaded;
         start_position <= next_start_position;
         stop_position <= next_stop_position;
         config_value <= next_config_value;
         overflow_flag <= next_overflow_flag;
         burn_position <= next_burn_position;
         burn_config <= next_burn_config;
         burn_count <= next_burn_count;
         addr_match <= next_addr_match;
         rd_data <= next_rd_data;
         ack_valid <= next_ack_valid;
         pointer <= rd_ptr;
         ctrl <= next_ctrl;
      end
   end
endmodule : rsr_register_bank
`default_nettype wire
